// ==== shared/asffe_pkg.sv ====
// constants for the serial frame front end of the sampling converter
// assumes a single 10 MHz system clock and APB access to the registers
package asffe_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int OSC_HZ = 2_500_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int CONV_CLKS = 14;
  localparam int FRAME_EDGES = 16;
  localparam int NORM_TRIG_EDGE = 4;
  localparam int SHORT_SAMPLE = 12;
  localparam int LONG_SAMPLE = 24;
  localparam int RESULT_W = 12;
  localparam int WORD_W = 16;
  localparam int CMD_W = 4;
  localparam int NUM_CH = 8;
  localparam int NUM_SELFTEST = 3;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] RESULT_OFS = 8'h08;
  localparam logic [7:0] CMD_OFS = 8'h0C;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int CTRL_LONG_BIT = 0;
  localparam int CTRL_SCLKCONV_BIT = 1;
  localparam int CTRL_EXT_BIT = 2;
  localparam int CTRL_FSMODE_BIT = 3;

  // ---------------------------------------------------------------
  // serial commands
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_LAST_SELECT = 4'hA;
  localparam logic [3:0] CMD_CONFIG = 4'hE;

  // sample and conversion sequence, gray along the usual path
  typedef enum logic [1:0] {
    ASFFE_IDLE = 2'b00,
    ASFFE_SAMPLE = 2'b01,
    ASFFE_CONVERT = 2'b11,
    ASFFE_DONE = 2'b10
  } asffe_state_e;
endpackage

// ==== shared/asffe_buf_if.sv ====
// valid/ready word channel between the front end and its result buffer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface asffe_buf_if #(parameter int W = 12);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== verilog/asffe_buf.sv ====
// two-entry result buffer with valid and ready on both sides
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps
module asffe_buf #(
  parameter int W = 12,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  asffe_buf_if.snk wr,
  asffe_buf_if.src rd
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  wire push = wr.valid && wr.ready;
  wire pop = rd.valid && rd.ready;

  assign wr.ready = (count_q != (PW+1)'(DEPTH));
  assign rd.valid = (count_q != '0);
  assign rd.data = mem[rdPtr_q];

  function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
    nextPtr = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wrPtr_q] <= wr.data;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= nextPtr(wrPtr_q);
      if (pop)
        rdPtr_q <= nextPtr(rdPtr_q);
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// ==== verilog/asffe_front_end.sv ====
// serial frame front end of a 12-bit sampling converter, APB registers
// assumes pins asynchronous to clk; analog core supplies its code on convCode
// Function
// - chip select fall clears counter, drives output
// - input stops after 16 edges or select rise
// - chip select rise tristates serial output
// - chip select may act as frame sync
// - normal sampling starts after fourth edge
// - sampling lasts 12 or 24 clock periods
// - sample start pin times extended sampling
// - conversion clock from oscillator or serial clock
// - mux selects channel or three self-tests
// - each conversion yields a 12-bit result
// - command in top four bits, msb first
// - capture rising edge, falling with frame sync
// - frame sync fall starts, tristate after 16th
// - sample start pin works while deselected
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module asffe_front_end
  import asffe_pkg::*;
#(
  parameter int OSC_DIVIDE = OSC_DIV,
  parameter int CONV_LEN = CONV_CLKS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chipSelectN,
  input wire logic frameSync,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic sampleStartN,
  output logic serialOut,
  output logic serialOutOe,
  input wire logic [RESULT_W-1:0] convCode,
  output logic [CMD_W-1:0] muxSel,
  output logic sampleActive,
  output logic convActive
);
  // ---------------------------------------------------------------
  // pin synchronisers and edges
  // ---------------------------------------------------------------
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] prev_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
      prev_q <= 5'h1f;
    end
    else
    begin
      sync1_q <= {sampleStartN, serialIn, serialClk, frameSync, chipSelectN};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  wire csS = sync2_q[0];
  wire sdiS = sync2_q[3];
  wire csFall = prev_q[0] && !sync2_q[0];
  wire csRise = !prev_q[0] && sync2_q[0];
  wire fsFall = prev_q[1] && !sync2_q[1];
  wire sclkRise = !prev_q[2] && sync2_q[2];
  wire sclkFall = prev_q[2] && !sync2_q[2];
  wire ssFall = prev_q[4] && !sync2_q[4];
  wire ssRise = !prev_q[4] && sync2_q[4];

  // ---------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------
  logic [3:0] ctrl_q;
  wire longSample = ctrl_q[CTRL_LONG_BIT];
  wire sclkConv = ctrl_q[CTRL_SCLKCONV_BIT];
  wire extMode = ctrl_q[CTRL_EXT_BIT];
  wire fsMode = ctrl_q[CTRL_FSMODE_BIT];

  // frame sync fall starts a frame while selected, else select fall does
  wire frameStart = fsMode ? (fsFall && !csS) : csFall;
  wire capEdge = fsMode ? sclkFall : sclkRise;
  wire shiftEdge = fsMode ? sclkRise : sclkFall;

  // ---------------------------------------------------------------
  // frame counter and input shifter
  // ---------------------------------------------------------------
  logic inEn_q;
  logic [3:0] edgeCnt_q;
  logic [WORD_W-1:0] shiftIn_q;
  logic [WORD_W-1:0] lastCmd_q;
  logic cmdValid_q;
  wire capture = capEdge && inEn_q;
  wire lastEdge = capture && (edgeCnt_q == 4'(FRAME_EDGES - 1));
  wire cutShort = csRise && inEn_q && (edgeCnt_q != 4'h0);
  wire [WORD_W-1:0] shiftNext = {shiftIn_q[WORD_W-2:0], sdiS};

  // blanks after an early select rise read as zeros
  function automatic logic [WORD_W-1:0] alignWord(input logic [WORD_W-1:0] w,
                                                  input logic [3:0] n);
    alignWord = w << (5'(WORD_W) - {1'b0, n});
  endfunction

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      inEn_q <= 1'b0;
      edgeCnt_q <= 4'h0;
      shiftIn_q <= '0;
      lastCmd_q <= '0;
      cmdValid_q <= 1'b0;
    end
    else
    begin
      cmdValid_q <= lastEdge || cutShort;
      if (frameStart)
      begin
        inEn_q <= 1'b1;
        edgeCnt_q <= 4'h0;
      end
      else if (lastEdge || csRise)
        inEn_q <= 1'b0;
      if (capture)
      begin
        shiftIn_q <= shiftNext;
        edgeCnt_q <= edgeCnt_q + 4'h1;
      end
      if (lastEdge)
        lastCmd_q <= shiftNext;
      else if (cutShort)
        lastCmd_q <= alignWord(shiftIn_q, edgeCnt_q);
    end
  end

  // ---------------------------------------------------------------
  // result buffer and serial output
  // ---------------------------------------------------------------
  asffe_buf_if #(.W(RESULT_W)) toBuf ();
  asffe_buf_if #(.W(RESULT_W)) fromBuf ();
  asffe_buf #(.W(RESULT_W), .DEPTH(2)) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .wr(toBuf.snk),
    .rd(fromBuf.src)
  );

  logic [RESULT_W-1:0] result_q;
  logic [WORD_W-1:0] outWord_q;
  logic outStarted_q;
  wire [RESULT_W-1:0] nextResult = fromBuf.valid ? fromBuf.data : result_q;
  assign fromBuf.ready = frameStart;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      result_q <= '0;
      outWord_q <= '0;
      outStarted_q <= 1'b0;
      serialOut <= 1'b0;
      serialOutOe <= 1'b0;
    end
    else if (frameStart)
    begin
      result_q <= nextResult;
      outWord_q <= {nextResult, 4'h0};
      serialOut <= nextResult[RESULT_W-1];
      serialOutOe <= 1'b1;
      outStarted_q <= 1'b0;
    end
    else if (csRise)
      serialOutOe <= 1'b0;
    else if (shiftEdge && serialOutOe)
    begin
      if (fsMode && !inEn_q)
        serialOutOe <= 1'b0;
      else if (outStarted_q)
      begin
        outWord_q <= {outWord_q[WORD_W-2:0], 1'b0};
        serialOut <= outWord_q[WORD_W-2];
      end
      outStarted_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // sample and conversion sequence
  // ---------------------------------------------------------------
  asffe_state_e state_q;
  logic [4:0] sampCnt_q;
  logic [4:0] convCnt_q;
  logic [7:0] oscCnt_q;
  logic oscTick_q;
  wire normTrig = capture && !extMode && (edgeCnt_q == 4'(NORM_TRIG_EDGE - 1));
  wire [4:0] sampLast = longSample ? 5'(LONG_SAMPLE - 1) : 5'(SHORT_SAMPLE - 1);
  wire convTick = sclkConv ? sclkRise : oscTick_q;
  wire extStart = extMode && csS && ssFall;
  wire extEnd = extMode && csS && ssRise;
  wire sampEnd = extMode ? extEnd : (sclkRise && sampCnt_q == sampLast);
  assign toBuf.valid = (state_q == ASFFE_DONE);
  assign toBuf.data = convCode;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      oscCnt_q <= 8'h00;
    else if (oscCnt_q == 8'(OSC_DIVIDE - 1))
      oscCnt_q <= 8'h00;
    else
      oscCnt_q <= oscCnt_q + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      oscTick_q <= 1'b0;
    else
      oscTick_q <= (oscCnt_q == 8'(OSC_DIVIDE - 1));
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= ASFFE_IDLE;
      sampCnt_q <= 5'h00;
      convCnt_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        ASFFE_IDLE:
          if (normTrig || extStart)
          begin
            state_q <= ASFFE_SAMPLE;
            sampCnt_q <= 5'h00;
          end
        ASFFE_SAMPLE:
          if (sampEnd)
          begin
            state_q <= ASFFE_CONVERT;
            convCnt_q <= 5'h00;
          end
          else if (sclkRise)
            sampCnt_q <= sampCnt_q + 5'h01;
        ASFFE_CONVERT:
          if (convTick)
          begin
            if (convCnt_q == 5'(CONV_LEN - 1))
              state_q <= ASFFE_DONE;
            else
              convCnt_q <= convCnt_q + 5'h01;
          end
        ASFFE_DONE:
          if (toBuf.ready)
            state_q <= ASFFE_IDLE;
        default:
          state_q <= ASFFE_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // mux select and status pins
  // ---------------------------------------------------------------
  wire [CMD_W-1:0] earlyCmd = {shiftIn_q[2:0], sdiS};
  wire selOk = (earlyCmd <= CMD_LAST_SELECT);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      muxSel <= 4'h0;
      sampleActive <= 1'b0;
      convActive <= 1'b0;
    end
    else
    begin
      if (capture && edgeCnt_q == 4'(NORM_TRIG_EDGE - 1) && selOk)
        muxSel <= earlyCmd;
      sampleActive <= (state_q == ASFFE_SAMPLE);
      convActive <= (state_q == ASFFE_CONVERT);
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  wire setup = psel && !penable && !pready;
  wire apbWr = psel && penable && pready && pwrite;
  wire hitCtrl = (paddr == CTRL_OFS);
  wire hitStat = (paddr == STATUS_OFS);
  wire hitRes = (paddr == RESULT_OFS);
  wire hitCmd = (paddr == CMD_OFS);
  wire hitAny = hitCtrl || hitStat || hitRes || hitCmd;
  wire cfgCmd = cmdValid_q && (lastCmd_q[15:12] == CMD_CONFIG);
  wire [31:0] rdMux = hitCtrl ? {28'h0000_000, ctrl_q} :
                      hitStat ? {23'h00_0000, inEn_q, edgeCnt_q, serialOutOe,
                                 fromBuf.valid, state_q} :
                      hitRes ? {20'h0_0000, result_q} :
                      hitCmd ? {16'h0000, lastCmd_q} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !hitAny;
      if (setup && !pwrite)
        prdata <= rdMux;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ctrl_q <= CTRL_RESET;
    else if (apbWr && hitCtrl)
      ctrl_q <= pwdata[3:0];
    else if (cfgCmd)
      ctrl_q <= lastCmd_q[3:0];
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_frame_open;
    @(posedge clk) disable iff (!rst_b)
    frameStart |=> inEn_q && serialOutOe && edgeCnt_q == 4'h0;
  endproperty
  a_frame_open: assert property (p_frame_open) else $error("frame start not opened");

  property p_stop_16;
    @(posedge clk) disable iff (!rst_b)
    (lastEdge && !frameStart) |=> !inEn_q && cmdValid_q;
  endproperty
  a_stop_16: assert property (p_stop_16) else $error("input open past 16 edges");

  property p_cs_rise;
    @(posedge clk) disable iff (!rst_b)
    (csRise && !frameStart) |=> !serialOutOe && !inEn_q;
  endproperty
  a_cs_rise: assert property (p_cs_rise) else $error("output driven after deselect");

  property p_norm_start;
    @(posedge clk) disable iff (!rst_b)
    (normTrig && state_q == ASFFE_IDLE) |=> state_q == ASFFE_SAMPLE ##1 sampleActive;
  endproperty
  a_norm_start: assert property (p_norm_start) else $error("sampling not started");

  property p_samp_len;
    @(posedge clk) disable iff (!rst_b)
    state_q == ASFFE_SAMPLE && !extMode |-> sampCnt_q <= sampLast;
  endproperty
  a_samp_len: assert property (p_samp_len) else $error("sample period overran");

  property p_ext_hold;
    @(posedge clk) disable iff (!rst_b)
    (state_q == ASFFE_SAMPLE && extMode && $past(extMode) && !extEnd)
      |=> state_q == ASFFE_SAMPLE;
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("extended sample ended early");

  property p_conv_clk;
    @(posedge clk) disable iff (!rst_b)
    (state_q == ASFFE_CONVERT && !convTick) |=> $stable(convCnt_q);
  endproperty
  a_conv_clk: assert property (p_conv_clk) else $error("conversion ran off its clock");

  property p_fs_tristate;
    @(posedge clk) disable iff (!rst_b)
    (fsMode && shiftEdge && serialOutOe && !inEn_q && !frameStart && !csRise)
      |=> !serialOutOe;
  endproperty
  a_fs_tristate: assert property (p_fs_tristate) else $error("output kept after 16th bit");

  property p_result_push;
    @(posedge clk) disable iff (!rst_b)
    (state_q == ASFFE_DONE && toBuf.ready) |=> state_q == ASFFE_IDLE;
  endproperty
  a_result_push: assert property (p_result_push) else $error("result not stored");
endmodule

// ==== tb/asffe_host_model.sv ====
// host serial port model: frames words into the front end, collects its output
// assumes clk is the 10 MHz system clock; serial clock period is 8 clk cycles
`timescale 1ns/100ps
module asffe_host_model (
  input wire logic clk,
  output logic chipSelectN,
  output logic frameSync,
  output logic serialClk,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutOe
);
  initial
  begin
    chipSelectN = 1'b1;
    frameSync = 1'b1;
    serialClk = 1'b1;
    serialIn = 1'b0;
  end

  // -----------------------------------------------------------------
  // frame driver
  // -----------------------------------------------------------------
  task automatic half(input logic lvl);
    serialClk <= lvl;
    repeat (4) @(posedge clk);
  endtask

  task automatic frame(input logic [15:0] wIn, input int n, input logic fs,
    output logic [15:0] wOut, output logic oeAll, output logic oeEnd,
    output logic oeOff);
    logic idle;
    idle = ~fs;
    wOut = 16'h0000;
    oeAll = 1'b1;
    @(posedge clk);
    half(idle);
    chipSelectN <= 1'b0;
    repeat (4) @(posedge clk);
    if (fs)
    begin
      frameSync <= 1'b0;
      repeat (4) @(posedge clk);
      frameSync <= 1'b1;
      repeat (4) @(posedge clk);
    end
    for (int i = 0; i < n; i++)
    begin
      // data changes on the opposite edge, msb first
      serialIn <= (i < 16) ? wIn[15 - i] : ~wIn[0];
      half(~idle);
      if (i < 16)
      begin
        wOut = {wOut[14:0], serialOut};
        oeAll = oeAll & serialOutOe;
      end
      half(idle);
    end
    if (fs)
      half(~idle);
    oeEnd = serialOutOe;
    if (fs)
      half(idle);
    chipSelectN <= 1'b1;
    // released line shows no stale value
    serialIn <= ~serialIn;
    repeat (5) @(posedge clk);
    oeOff = serialOutOe;
  endtask
endmodule

// ==== tb/asffe_front_end_tb_top.sv ====
// self-checking bench for the serial frame front end
// assumes the host model drives the serial pins and this bench drives APB and sampleStartN
`timescale 1ns/100ps
module asffe_front_end_tb_top
  import asffe_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic chipSelectN, frameSync, serialClk, serialIn, serialOut, serialOutOe;
  logic sampleStartN = 1'b1;
  logic [RESULT_W-1:0] convCode = 12'h000;
  logic [CMD_W-1:0] muxSel;
  logic sampleActive, convActive;
  logic [15:0] wOut;
  logic oeAll, oeEnd, oeOff;
  int miscompares = 0;
  int checks = 0;

  always #50 clk = ~clk;

  asffe_front_end #(.OSC_DIVIDE(4), .CONV_LEN(2)) DUT (.clk(clk), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .chipSelectN(chipSelectN),
    .frameSync(frameSync), .serialClk(serialClk), .serialIn(serialIn),
    .sampleStartN(sampleStartN), .serialOut(serialOut), .serialOutOe(serialOutOe),
    .convCode(convCode), .muxSel(muxSel), .sampleActive(sampleActive),
    .convActive(convActive));

  asffe_host_model host (.clk(clk), .chipSelectN(chipSelectN), .frameSync(frameSync),
    .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutOe(serialOutOe));

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    // slave answers in the first access cycle
    check(32'(n), 32'h0000_0001);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
    apb(a, 1'b0, 32'h0000_0000);
    check(rd, exp);
    check(32'(err), 32'(e));
  endtask

  task automatic run(input logic [15:0] w, input int n, input logic fs);
    host.frame(w, n, fs, wOut, oeAll, oeEnd, oeOff);
    repeat (20) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------------
  initial
  begin
    logic [11:0] prev;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rdchk(CTRL_OFS, 32'h0000_0000, 1'b0);
    apb(CTRL_OFS, 1'b1, 32'hFFFF_FFF1);
    rdchk(CTRL_OFS, 32'h0000_0001, 1'b0);
    rdchk(8'h10, 32'h0000_0000, 1'b1);
    apb(CTRL_OFS, 1'b1, 32'h0000_0000);
    for (int ch = 0; ch < NUM_CH + NUM_SELFTEST; ch++)
    begin
      convCode <= 12'hA50 ^ 12'(ch * 37);
      run({4'(ch), 12'h000}, FRAME_EDGES, 1'b0);
      check(32'(muxSel), 32'(ch));
      check(32'({oeAll, oeEnd, oeOff}), 32'h0000_0006);
      if (ch > 0)
        check(32'(wOut), 32'({prev, 4'h0}));
      if (ch > 0)
        rdchk(RESULT_OFS, 32'(prev), 1'b0);
      rdchk(CMD_OFS, 32'({4'(ch), 12'h000}), 1'b0);
      check(32'(convActive), 32'h0000_0000);
      prev = convCode;
    end
    for (int lp = 0; lp < 2; lp++)
    begin
      apb(CTRL_OFS, 1'b1, 32'(lp));
      run(16'h1000, NORM_TRIG_EDGE + (lp ? LONG_SAMPLE : SHORT_SAMPLE) - 1, 1'b0);
      check(32'(sampleActive), 32'h0000_0001);
      run(16'h1000, NORM_TRIG_EDGE + (lp ? LONG_SAMPLE : SHORT_SAMPLE), 1'b0);
      check(32'(sampleActive), 32'h0000_0000);
      rdchk(CMD_OFS, 32'h0000_1000, 1'b0);
    end
    apb(CTRL_OFS, 1'b1, 32'h0000_0002);
    run(16'h2000, FRAME_EDGES, 1'b0);
    check(32'(convActive), 32'h0000_0001);
    run({CMD_CONFIG, 12'h004}, FRAME_EDGES, 1'b0);
    rdchk(CTRL_OFS, 32'h0000_0004, 1'b0);
    for (int k = 0; k < 200 && (sampleActive !== 1'b0 || convActive !== 1'b0); k++)
      @(posedge clk);
    // drain leftovers so the buffer starts empty
    repeat (2) run(16'h0000, FRAME_EDGES, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      convCode <= 12'h3C0 + 12'(k);
      sampleStartN <= 1'b0;
      repeat (8) @(posedge clk);
      check(32'({sampleActive, convActive}), 32'h0000_0002);
      sampleStartN <= 1'b1;
      for (int j = 0; j < 12 && convActive !== 1'b1; j++)
        @(posedge clk);
      check(32'({sampleActive, convActive}), 32'h0000_0001);
      repeat (20) @(posedge clk);
    end
    // third result waits for room in the full buffer
    apb(STATUS_OFS, 1'b0, 32'h0000_0000);
    check(32'(rd[1:0]), 32'(ASFFE_DONE));
    for (int k = 0; k < 4; k++)
    begin
      run(16'h0000, FRAME_EDGES, 1'b0);
      check(32'(wOut), 32'({12'h3C0 + 12'(k == 3 ? 2 : k), 4'h0}));
    end
    apb(CTRL_OFS, 1'b1, 32'h0000_0008);
    run(16'h5000, FRAME_EDGES, 1'b1);
    check(32'({oeAll, oeEnd, oeOff}), 32'h0000_0004);
    check(32'(wOut), 32'({12'h3C2, 4'h0}));
    check(32'(muxSel), 32'h0000_0005);
    rdchk(CMD_OFS, 32'h0000_5000, 1'b0);
    tally_and_finish();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
endmodule
